// file: crystal_model.sv
// crystal oscillator model driving the crystal pin
`timescale 1ns/1ps

module crystal_model #(
	parameter int HALF_NS = 41
) (
	input  wire  run,
	output logic xtal
);
	// a halted crystal holds its level, as a stopped oscillator would
	initial begin
		xtal = 1'b0;
		forever begin
			#HALF_NS;
			if (run)
				xtal = !xtal;
		end
	end
endmodule

// file: rtc_trim_checker.sv
// concurrent checks on the ports of the rate trim and supply status block
`timescale 1ns/1ps
`include "rtc_trim_defs.vh"

module rtc_trim_checker #(
	parameter [14:0] OSC_HALT_CYCLES = 15'h0032
) (
	input logic        pclk,
	input logic        presetn,
	input logic        psel,
	input logic        penable,
	input logic        pwrite,
	input logic [7:0]  paddr,
	input logic [31:0] pwdata,
	input logic [31:0] prdata,
	input logic        pready,
	input logic        pslverr,
	input logic        crystal_clock_in,
	input logic        supply_below_threshold,
	input logic        power_from_zero,
	input logic        crystal_clock_out,
	input logic        second_tick,
	input logic        trim_second_active,
	input logic        supply_threshold_select,
	input logic [7:0]  control_one_value
);
	// ----------------------------------------------------------------
	// helper logic
	// ----------------------------------------------------------------
	logic [2:0] up_cnt;
	logic [7:0] c1_exp;
	logic       c2_exp;
	wire        acc    = psel && penable && pready;
	wire        wr_c1  = acc && pwrite && (paddr == `ADDR_CONTROL_ONE);
	wire        wr_c2  = acc && pwrite && (paddr == `ADDR_CONTROL_TWO);
	wire        mapped = (paddr == `ADDR_CONTROL_ONE) || (paddr == `ADDR_CONTROL_TWO)
		|| (paddr == `ADDR_RATE_TRIM);

	// the synchronizer history is only valid once it has refilled after reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			up_cnt <= 3'h0;
			c1_exp <= 8'h00;
			c2_exp <= 1'b0;
		end else begin
			if (up_cnt != 3'h7)
				up_cnt <= up_cnt + 3'h1;
			if (wr_c1)
				c1_exp <= pwdata[7:0];
			if (wr_c2)
				c2_exp <= pwdata[7];
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_one_wait: assert property (psel && penable && !pready |=> pready ##1 !pready)
		else $error("ready not after exactly one wait state");
	a_err_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0000_0000)
		else $error("refused read returned data");
	a_mapped_ok: assert property (pready && mapped |-> !pslverr)
		else $error("mapped register refused");
	a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h00_0000)
		else $error("upper read bits not zero");
	a_clkout_raw: assert property (up_cnt == 3'h7 |-> crystal_clock_out == $past(crystal_clock_in, 3))
		else $error("crystal output not a plain delayed copy");
	a_ctrl_copy: assert property (wr_c1 |-> ##2 control_one_value == c1_exp)
		else $error("control one copy did not follow write");
	a_thresh_sel: assert property (wr_c2 |-> ##[1:2] supply_threshold_select == c2_exp)
		else $error("threshold select did not follow write");
	a_power_clear: assert property ($rose(power_from_zero) |-> ##[2:6] (control_one_value == 8'h00 && !supply_threshold_select))
		else $error("power up event did not clear controls");
	a_tick_pulse: assert property (second_tick |=> !second_tick)
		else $error("second tick longer than one cycle");
	a_trim_at_tick: assert property ($changed(trim_second_active) |-> second_tick)
		else $error("trimmed second marker moved between ticks");

	cover property (wr_c2);
	cover property (pready && pslverr);
	cover property ($rose(power_from_zero));
	cover property (wr_c1);
endmodule

bind rtc_trim_top rtc_trim_checker #(.OSC_HALT_CYCLES(OSC_HALT_CYCLES)) u_chk (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.crystal_clock_in(crystal_clock_in), .supply_below_threshold(supply_below_threshold),
	.power_from_zero(power_from_zero), .crystal_clock_out(crystal_clock_out),
	.second_tick(second_tick), .trim_second_active(trim_second_active),
	.supply_threshold_select(supply_threshold_select), .control_one_value(control_one_value)
);

// file: rtc_trim_defs.vh
// constants for the rate trim and supply status block

`ifndef RTC_TRIM_DEFS_VH
`define RTC_TRIM_DEFS_VH

// ----------------------------------------------------------------
// register indices and byte addresses
// ----------------------------------------------------------------
`define IDX_RATE_TRIM       6'h07
`define IDX_CONTROL_ONE     6'h0e
`define IDX_CONTROL_TWO     6'h0f
`define ADDR_RATE_TRIM      {`IDX_RATE_TRIM, 2'b00}
`define ADDR_CONTROL_ONE    {`IDX_CONTROL_ONE, 2'b00}
`define ADDR_CONTROL_TWO    {`IDX_CONTROL_TWO, 2'b00}

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define TRIM_INTERVAL_BIT   7
`define SUPPLY_THRESH_BIT   7
`define SUPPLY_LOW_BIT      6
`define OSC_RUN_N_BIT       5
`define POWER_UP_BIT        4
`define CLKOUT_ONE_BIT      3

// ----------------------------------------------------------------
// reset values and codes
// ----------------------------------------------------------------
`define CONTROL_ONE_RST     8'h00
`define RATE_TRIM_RST       8'h00
`define TRIM_CODE_ZERO      7'h00
`define TRIM_CODE_PLUS_ONE  7'h01
`define TRIM_CODE_MINUS_64  7'h40
`define TRIM_CODE_MINUS_63  7'h41
`define TRIM_NEG_BASE       16'h0080

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define PRESCALE_TERMINAL   16'h7fff
`define INTERVAL_SHORT      6'h14
`define INTERVAL_LONG       6'h3c
`define CLK_PERIOD_NS       5
`define OSC_HALT_TIME_NS    100000
`define OSC_HALT_CYCLES_DEF 15'h4e20 // 100 us of 5 ns cycles

`endif

// file: rtc_trim_second.v
// trimmed one-second timebase from crystal edges
`timescale 1ns/1ps
`include "rtc_trim_defs.vh"

module rtc_trim_second (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        xtal_rise,
	input  wire [7:0]  rate_trim,
	output reg         second_tick,
	output reg         trim_second_active
);

	reg  [15:0] presc;
	reg  [5:0]  sec_in_interval;
	reg  [15:0] terminal;
	reg  [15:0] next_terminal;
	wire [6:0]  code;
	wire [5:0]  interval_len;
	wire        wrap;

	assign code = rate_trim[6:0];

	// ----------------------------------------------------------------
	// trim code to terminal count
	// ----------------------------------------------------------------
	always @* begin
		next_terminal = `PRESCALE_TERMINAL;
		if (code == `TRIM_CODE_ZERO || code == `TRIM_CODE_PLUS_ONE ||
		    code == `TRIM_CODE_MINUS_64 || code == `TRIM_CODE_MINUS_63) begin
			next_terminal = `PRESCALE_TERMINAL;
		end else if (!code[6]) begin
			// lengthen by code minus one counts
			next_terminal = `PRESCALE_TERMINAL + {9'h000, code} - 16'h0001;
		end else begin
			// shorten by 128 minus code counts
			next_terminal = `PRESCALE_TERMINAL - `TRIM_NEG_BASE + {9'h000, code};
		end
	end

	assign interval_len = rate_trim[`TRIM_INTERVAL_BIT] ? `INTERVAL_LONG
	                                                   : `INTERVAL_SHORT;
	// >= so a shorter interval chosen mid-way still wraps
	assign wrap = (sec_in_interval >= interval_len - 6'h01);

	// ----------------------------------------------------------------
	// prescaler and interval position
	// ----------------------------------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			presc              <= 16'h0000;
			sec_in_interval    <= 6'h00;
			terminal           <= `PRESCALE_TERMINAL;
			second_tick        <= 1'b0;
			trim_second_active <= 1'b0;
		end else begin
			second_tick <= 1'b0;
			if (xtal_rise) begin
				if (presc >= terminal) begin
					presc       <= 16'h0000;
					second_tick <= 1'b1;
					if (wrap) begin
						// first second of each interval is the trimmed one
						sec_in_interval    <= 6'h00;
						terminal           <= next_terminal;
						trim_second_active <= 1'b1;
					end else begin
						sec_in_interval    <= sec_in_interval + 6'h01;
						terminal           <= `PRESCALE_TERMINAL;
						trim_second_active <= 1'b0;
					end
				end else begin
					presc <= presc + 16'h0001;
				end
			end
		end
	end

endmodule

// file: rtc_trim_top.v
// rate trim and supply status registers behind an apb slave
`timescale 1ns/1ps
`include "rtc_trim_defs.vh"

module rtc_trim_top #(
	parameter [14:0] OSC_HALT_CYCLES = `OSC_HALT_CYCLES_DEF
) (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	input  wire        crystal_clock_in,
	input  wire        supply_below_threshold,
	input  wire        power_from_zero,
	output reg         crystal_clock_out,
	output wire        second_tick,
	output wire        trim_second_active,
	output reg         supply_threshold_select,
	output reg  [7:0]  control_one_value
);

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	localparam PIN_COUNT = 3;

	wire [PIN_COUNT-1:0] pin_raw;
	reg  [PIN_COUNT-1:0] sync_a;
	reg  [PIN_COUNT-1:0] sync_b;
	reg  [PIN_COUNT-1:0] pin_last;

	wire        xtal_level;
	wire        xtal_rise;
	wire        xtal_edge;
	wire        supply_low_level;
	wire        power_rise;

	reg  [14:0] halt_count;
	wire        halt_event;
	wire        power_event;

	reg  [7:0]  control_one;
	reg  [7:0]  rate_trim;
	reg         power_up_flag;
	reg         osc_running_flag_n;
	reg         supply_low_flag;
	reg         clkout_enable_one;

	wire        access;
	wire        start;
	wire        wr_strobe;
	wire        hit_trim;
	wire        hit_one;
	wire        hit_two;
	wire        addr_hit;
	wire [7:0]  control_two_status;
	reg  [7:0]  read_byte;

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	assign pin_raw = {power_from_zero, supply_below_threshold, crystal_clock_in};

	genvar gi;
	generate
		for (gi = 0; gi < PIN_COUNT; gi = gi + 1) begin : g_sync
			always @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					sync_a[gi]   <= 1'b0;
					sync_b[gi]   <= 1'b0;
					pin_last[gi] <= 1'b0;
				end else begin
					sync_a[gi]   <= pin_raw[gi];
					sync_b[gi]   <= sync_a[gi];
					pin_last[gi] <= sync_b[gi];
				end
			end
		end
	endgenerate

	assign xtal_level       = sync_b[0];
	assign supply_low_level = sync_b[1];
	assign xtal_rise        = sync_b[0] & ~pin_last[0];
	assign xtal_edge        = sync_b[0] ^ pin_last[0];
	assign power_rise       = sync_b[2] & ~pin_last[2];

	// ----------------------------------------------------------------
	// untrimmed crystal clock output
	// ----------------------------------------------------------------
	// taken before the trim logic, so its rate never moves
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			crystal_clock_out <= 1'b0;
		end else begin
			crystal_clock_out <= xtal_level;
		end
	end

	// ----------------------------------------------------------------
	// oscillator halt detector
	// ----------------------------------------------------------------
	// a missing crystal edge for the whole window counts as a halt;
	// the counter parks at the limit so the event fires once per halt
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			halt_count <= 15'h0000;
		end else if (xtal_edge) begin
			halt_count <= 15'h0000;
		end else if (halt_count != OSC_HALT_CYCLES) begin
			halt_count <= halt_count + 15'h0001;
		end
	end

	assign halt_event = !xtal_edge && (halt_count == OSC_HALT_CYCLES - 15'h0001);

	// ----------------------------------------------------------------
	// power-up from zero event
	// ----------------------------------------------------------------
	// the reset itself stands for the first power-up; a later pulse on
	// the detector pin repeats the same clearing, except that the
	// oscillator running flag keeps its value
	assign power_event = power_rise;

	// ----------------------------------------------------------------
	// trimmed one-second timebase
	// ----------------------------------------------------------------
	rtc_trim_second u_second (
		.pclk               (pclk),
		.presetn            (presetn),
		.xtal_rise          (xtal_rise),
		.rate_trim          (rate_trim),
		.second_tick        (second_tick),
		.trim_second_active (trim_second_active)
	);

	// ----------------------------------------------------------------
	// apb decode
	// ----------------------------------------------------------------
	// one wait state: pready rises in the second access cycle
	assign access    = psel & penable;
	assign start     = access & ~pready;
	assign wr_strobe = access & pready & pwrite;

	assign hit_trim = (paddr == `ADDR_RATE_TRIM);
	assign hit_one  = (paddr == `ADDR_CONTROL_ONE);
	assign hit_two  = (paddr == `ADDR_CONTROL_TWO);
	assign addr_hit = hit_trim | hit_one | hit_two;

	// ----------------------------------------------------------------
	// control register one
	// ----------------------------------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			control_one <= `CONTROL_ONE_RST;
		end else if (power_event) begin
			control_one <= `CONTROL_ONE_RST;
		end else if (wr_strobe && hit_one) begin
			control_one <= pwdata[7:0];
		end
	end

	// ----------------------------------------------------------------
	// rate trim register
	// ----------------------------------------------------------------
	// the host must keep codes within -62..63 for a real correction
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rate_trim <= `RATE_TRIM_RST;
		end else if (power_event) begin
			rate_trim <= `RATE_TRIM_RST;
		end else if (wr_strobe && hit_trim) begin
			rate_trim <= pwdata[7:0];
		end
	end

	// ----------------------------------------------------------------
	// control register two: power-up flag
	// ----------------------------------------------------------------
	// set beats a clearing write in the same cycle
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			power_up_flag <= 1'b1;
		end else if (power_event) begin
			power_up_flag <= 1'b1;
		end else if (wr_strobe && hit_two && !pwdata[`POWER_UP_BIT]) begin
			power_up_flag <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// control register two: oscillator running flag
	// ----------------------------------------------------------------
	// undefined after power-up; held at zero, the safe reading.
	// a halt wins over any write in the same cycle
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			osc_running_flag_n <= 1'b0;
		end else if (halt_event) begin
			osc_running_flag_n <= 1'b0;
		end else if (wr_strobe && hit_two) begin
			osc_running_flag_n <= pwdata[`OSC_RUN_N_BIT];
		end
	end

	// ----------------------------------------------------------------
	// control register two: supply low flag
	// ----------------------------------------------------------------
	// the comparator follows the threshold select output; once the
	// flag is set it stays until cleared, and a low sample wins over a clearing write
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			supply_low_flag <= 1'b0;
		end else if (power_event) begin
			supply_low_flag <= 1'b0;
		end else if (supply_low_level) begin
			supply_low_flag <= 1'b1;
		end else if (wr_strobe && hit_two && !pwdata[`SUPPLY_LOW_BIT]) begin
			supply_low_flag <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// control register two: plain control bits
	// ----------------------------------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			supply_threshold_select <= 1'b0;
			clkout_enable_one       <= 1'b0;
		end else if (power_event) begin
			supply_threshold_select <= 1'b0;
			clkout_enable_one       <= 1'b0;
		end else if (wr_strobe && hit_two) begin
			supply_threshold_select <= pwdata[`SUPPLY_THRESH_BIT];
			clkout_enable_one       <= pwdata[`CLKOUT_ONE_BIT];
		end
	end

	// ----------------------------------------------------------------
	// status byte assembly
	// ----------------------------------------------------------------
	// alarm and periodic flags live elsewhere and read as zero here
	assign control_two_status = {supply_threshold_select,
	                             supply_low_flag,
	                             osc_running_flag_n,
	                             power_up_flag,
	                             clkout_enable_one,
	                             3'b000};

	// ----------------------------------------------------------------
	// read multiplexer
	// ----------------------------------------------------------------
	always @* begin
		read_byte = 8'h00;
		if (hit_trim) begin
			read_byte = rate_trim;
		end else if (hit_one) begin
			read_byte = control_one;
		end else if (hit_two) begin
			read_byte = control_two_status;
		end
	end

	// ----------------------------------------------------------------
	// apb answer
	// ----------------------------------------------------------------
	// prdata holds its value between transfers to keep the bus quiet
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= start;
			pslverr <= start & ~addr_hit;
			if (start && !pwrite) begin
				prdata <= {24'h00_0000, read_byte};
			end
		end
	end

	// ----------------------------------------------------------------
	// control one to the alarm and periodic logic
	// ----------------------------------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			control_one_value <= `CONTROL_ONE_RST;
		end else begin
			control_one_value <= control_one;
		end
	end

endmodule

// file: tb.sv
// self-checking testbench for the rate trim and supply status block
`timescale 1ns/1ps
`include "rtc_trim_defs.vh"

module tb;
	localparam logic [7:0] C1 = `ADDR_CONTROL_ONE;
	localparam logic [7:0] C2 = `ADDR_CONTROL_TWO;
	localparam logic [7:0] TR = `ADDR_RATE_TRIM;
	logic        pclk, presetn, psel, penable, pwrite, sup_low, pwr_up, xtal_run;
	logic [7:0]  paddr, r;
	logic [31:0] pwdata;
	wire  [31:0] prdata;
	wire  [7:0]  c1_val;
	wire         pready, pslverr, xtal, clk_out, tick, trim_act, thresh;
	int          err_total, comparisons, v;
	logic [32:0] exp_q[$];

	// short halt time keeps the halt scenario brief with an 82 ns crystal
	rtc_trim_top #(.OSC_HALT_CYCLES(15'h0032)) u_dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.crystal_clock_in(xtal), .supply_below_threshold(sup_low), .power_from_zero(pwr_up),
		.crystal_clock_out(clk_out), .second_tick(tick), .trim_second_active(trim_act),
		.supply_threshold_select(thresh), .control_one_value(c1_val));
	crystal_model u_xtal (.run(xtal_run), .xtal(xtal));

	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end

	task automatic check(input logic [32:0] seen, input logic [32:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic results;
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask

	// the request stands until the edge at which pready is seen high;
	// no trimmed second is measured here, so the access rate is free
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20)
			err_total++;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [32:0] e);
		exp_q.push_back(e);
		apb(1'b0, a, 32'h0000_0000);
	endtask

	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1 && !pwrite)
			check({pslverr, prdata}, exp_q.pop_front());
	end

	initial begin
		cyc(20000);
		err_total++;
		results();
	end

	initial begin
		{psel, penable, pwrite, sup_low, pwr_up, presetn} = 6'h00;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		xtal_run = 1'b1;
		err_total = 0;
		comparisons = 0;
		void'($urandom(50));
		cyc(20);
		presetn <= 1'b1;
		rd(C2, 33'h0_0000_0010);
		rd(TR, 33'h0_0000_0000);
		rd(C1, 33'h0_0000_0000);
		apb(1'b1, C1, 32'h0000_0003);
		rd(C1, 33'h0_0000_0003);
		check(33'(c1_val), 33'h0_0000_0003);
		r = 8'($urandom);
		apb(1'b1, C1, {24'h00_0000, r});
		rd(C1, {25'h000_0000, r});
		apb(1'b1, C2, 32'h0000_00ff);
		rd(C2, 33'h0_0000_00b8);
		check(33'(thresh), 33'h0_0000_0001);
		apb(1'b1, C2, 32'h0000_0020);
		rd(C2, 33'h0_0000_0020);
		sup_low <= 1'b1;
		cyc(5);
		rd(C2, 33'h0_0000_0060);
		apb(1'b1, C2, 32'h0000_0020);
		rd(C2, 33'h0_0000_0060);
		sup_low <= 1'b0;
		cyc(5);
		apb(1'b1, C2, 32'h0000_0020);
		rd(C2, 33'h0_0000_0020);
		xtal_run <= 1'b0;
		cyc(80);
		rd(C2, 33'h0_0000_0000);
		xtal_run <= 1'b1;
		cyc(40);
		apb(1'b1, C2, 32'h0000_0020);
		rd(C2, 33'h0_0000_0020);
		for (int i = 0; i < 8; i++) begin
			v = (i == 0) ? -62 : (i == 1) ? 63 : int'($urandom_range(125)) - 62;
			r = {1'($urandom_range(1)), 7'(v < 0 ? 128 + v : v)};
			// a crystal 1 Hz slow on the 60 s interval needs 2 * 30 steps
			if (i == 2)
				r = {1'b1, 7'(128 - 2 * 30)};
			apb(1'b1, TR, {24'h00_0000, r});
			rd(TR, {25'h000_0000, r});
		end
		rd(8'h00, 33'h1_0000_0000);
		apb(1'b1, TR, 32'h0000_0085);
		apb(1'b1, C1, 32'h0000_00a5);
		apb(1'b1, C2, 32'h0000_00a0);
		pwr_up <= 1'b1;
		cyc(6);
		rd(C1, 33'h0_0000_0000);
		rd(TR, 33'h0_0000_0000);
		rd(C2, 33'h0_0000_0030);
		check(33'(c1_val), 33'h0_0000_0000);
		check(33'(thresh), 33'h0_0000_0000);
		pwr_up <= 1'b0;
		cyc(5);
		check(33'(exp_q.size()), 33'h0_0000_0000);
		results();
	end
endmodule
